/* File: ars_chk.sv */
// ars_chk: port checks of the address resolution slave.
// assumes link events spaced two link cycles apart by the bench.
`timescale 1ns/1ns
module ars_chk import ars_pkg::*; (
  // device domain
  input wire logic clk,
  input wire logic resetn,
  input wire ars_stat_t stat,
  // link domain
  input wire logic link_clk,
  input wire ars_evt_t evt,
  input wire ars_rsp_t rsp
);
  // ------------------------------
  // decode helpers
  // ------------------------------
  wire logic [7:0] d = evt.data;                 // byte on the event bus
  wire logic rsv = d == 8'h00 || (d >= 8'h05 && d <= 8'h1F) || d >= 8'hFE;
  wire logic gen = d >= 8'h01 && d <= 8'h04;     // general codes
  wire logic dir = !rsv && !gen;                 // directed codes
  wire logic hit = stat.valid && d[7:1] == stat.addr;  // stat settles well inside a link cycle
  wire logic wa = evt.addr_valid && d == 8'hC2;  // write to resolution address
  // ------------------------------
  // link domain checks
  // ------------------------------
  a_addr_nack: assert property (@(posedge link_clk) disable iff (!resetn)
    evt.addr_valid && d[7:1] != 7'h61 |=> rsp.ack_valid && !rsp.ack) else $error("foreign acked");
  a_reserved_nack: assert property (@(posedge link_clk) disable iff (!resetn)
    wa ##2 (evt.rx_valid && rsv) |=> rsp.ack_valid && !rsp.ack) else $error("reserved acked");
  a_general_ack: assert property (@(posedge link_clk) disable iff (!resetn)
    wa ##2 (evt.rx_valid && gen) |=> rsp.ack_valid && rsp.ack) else $error("general refused");
  a_dir_miss: assert property (@(posedge link_clk) disable iff (!resetn)
    wa ##2 (evt.rx_valid && dir && !hit) |=> rsp.ack_valid && !rsp.ack) else $error("miss acked");
  a_dir_hit: assert property (@(posedge link_clk) disable iff (!resetn)
    wa ##2 (evt.rx_valid && dir && hit) |=> rsp.ack_valid && rsp.ack) else $error("hit refused");
  a_read_gate: assert property (@(posedge link_clk) disable iff (!resetn)
    wa ##2 (evt.rx_valid && d == 8'h03) ##2 (evt.addr_valid && d == 8'hC3)
    |=> rsp.ack_valid && rsp.ack == !stat.resolved) else $error("read gate wrong");
  a_block_count: assert property (@(posedge link_clk) disable iff (!resetn)
    (evt.addr_valid && d == 8'hC3) ##1 rsp.ack ##1 evt.tx_req
    |=> rsp.tx_valid && rsp.tx_data == 8'h11) else $error("count byte wrong");
  a_addr_byte: assert property (@(posedge link_clk) disable iff (!resetn)
    rsp.tx_valid && rsp.tx_last |-> rsp.tx_data == {(stat.valid ? stat.addr : 7'h7F), 1'b1})
    else $error("address byte wrong");
  // ------------------------------
  // device domain checks
  // ------------------------------
  a_valid_rise: assert property (@(posedge clk) disable iff (!resetn)
    $rose(stat.valid) |-> stat.resolved) else $error("valid without resolved");
  a_notify_fall: assert property (@(posedge clk) disable iff (!resetn)
    $fell(stat.notify) |-> !stat.resolved) else $error("notify dropped while resolved");
  // main scenarios reached
  c_adopt: cover property (@(posedge clk) disable iff (!resetn) $rose(stat.resolved));
  c_hit: cover property (@(posedge link_clk) disable iff (!resetn) wa ##2 (evt.rx_valid && hit));
  c_read: cover property (@(posedge link_clk) disable iff (!resetn) rsp.tx_valid && rsp.tx_last);
endmodule : ars_chk

bind ars_slave ars_chk ars_chk_inst (.clk, .resetn, .stat, .link_clk, .evt, .rsp);

/* File: ars_host.sv */
// ars_host: behavioural resolution master on the byte-event bus.
// assumes the slave answers one link cycle after each event.
`timescale 1ns/1ns
module ars_host import ars_pkg::*; (
  // link domain
  input wire logic link_clk,
  output ars_evt_t evt,
  input wire ars_rsp_t rsp
);
  // quiet bus until the first packet
  initial evt = '0;
  // one event for one link cycle; data then inverted so stale bytes never match
  task send(input logic [5:0] f, input logic [7:0] b, output ars_rsp_t r);
    @(posedge link_clk);
    evt <= {f, b};
    @(posedge link_clk);
    evt <= {6'h00, ~b};
    #1;
    r = rsp;
  endtask : send
  // an enumerator would use only prepare, reads and assign
  task start(input logic rd, output ars_rsp_t r);
    send(6'h20, {ARS_DEFAULT_ADDR, rd}, r);
  endtask : start
endmodule : ars_host

/* File: ars_pkg.sv */
// ars_pkg: constants and carrier types of the address resolution slave.
// assumes a byte-level bus engine that reports address, data, read
// requests and stop conditions, and computes the packet check value.
package ars_pkg;

  // ----------------------------------------------------------------
  // addressing and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ARS_DEFAULT_ADDR = 7'h61;   // fixed resolution address
  localparam logic [7:0] ARS_CMD_PREPARE = 8'h01;
  localparam logic [7:0] ARS_CMD_RESET_GEN = 8'h02;
  localparam logic [7:0] ARS_CMD_GET_GEN = 8'h03;
  localparam logic [7:0] ARS_CMD_ASSIGN = 8'h04;
  localparam logic [7:0] ARS_CMD_GEN_LAST = 8'h1F;   // top of general range
  localparam logic [7:0] ARS_CMD_RSV_FE = 8'hFE;
  localparam logic [7:0] ARS_CMD_RSV_FF = 8'hFF;

  // ----------------------------------------------------------------
  // packet layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ARS_BLOCK_COUNT = 8'h11;    // count byte of id block
  localparam logic [4:0] ARS_IDX_COUNT = 5'h00;      // count byte position
  localparam logic [4:0] ARS_IDX_ADDR = 5'h11;       // address byte position
  localparam logic [4:0] ARS_IDX_PEC = 5'h12;        // check byte position
  localparam logic [6:0] ARS_NO_ADDR = 7'h7F;        // upper bits when invalid
  localparam logic [1:0] ARS_TYPE_FIXED = 2'h0;      // id bits 127:126, fixed
  localparam int ARS_UNIQUE_DEVICE_IDENTIFIER_W = 128;
  localparam int ARS_RAND_W = 32;                    // random id portion

  // ----------------------------------------------------------------
  // reset values and start-up timing
  // ----------------------------------------------------------------
  localparam logic [1:0] ARS_INIT_LOAD = 2'h2;       // edges until straps settle
  localparam logic [1:0] ARS_INIT_DONE = 2'h3;
  localparam logic [4:0] ARS_IDX_RST = 5'h00;

  // link-side state, one-hot
  typedef enum logic [7:0] {
    ARS_IDLE = 8'h01,
    ARS_CMD = 8'h02,
    ARS_PEC_PREP = 8'h04,
    ARS_PEC_RST = 8'h08,
    ARS_WAIT_RD = 8'h10,
    ARS_READ = 8'h20,
    ARS_ASSIGN = 8'h40,
    ARS_DROP = 8'h80
  } ars_state_t;

  // events from the byte engine, one link cycle each
  typedef struct packed {
    logic addr_valid;    // address byte seen, data holds it
    logic rx_valid;      // data byte received
    logic pec_ok;        // data byte equals running check value
    logic tx_req;        // engine needs next read byte
    logic stop;          // stop condition
    logic collision;     // lost arbitration while read at own address
    logic [7:0] data;
  } ars_evt_t;

  // answers to the byte engine
  typedef struct packed {
    logic ack_valid;     // answer to addr_valid or rx_valid
    logic ack;           // 1 acknowledge, 0 refuse
    logic tx_valid;      // answer to tx_req
    logic tx_last;       // last byte before the check byte
    logic [7:0] tx_data;
  } ars_rsp_t;

  // resolution state seen by the rest of the device
  typedef struct packed {
    logic notify;        // resolution wanted, not yet cancelled
    logic resolved;      // address_resolved_flag
    logic valid;         // address_valid_flag
    logic [6:0] addr;    // slave address
  } ars_stat_t;

endpackage : ars_pkg

/* File: ars_slave.sv */
// ars_slave: address resolution command logic of a bus slave.
// assumes a byte engine on link_clk handling bits, check value and
// acknowledge timing; it waits for rsp one link cycle after each event.
`timescale 1ns/1ns

// Functional notes
// - power-on clears resolved, loads or clears valid
// - packets use default address with check
// - general codes 01 to 04 decoded
// - odd upper code: directed identifier read
// - even upper code: directed resolution reset
// - codes FE and FF never directed
// - fixed device accepts assign, keeps address
// - prepare acks, clears resolved, cancels notify
// - general reset clears resolved, maybe valid
// - resets touch resolution state and renew random id
// - general read answered only while unresolved
// - address byte lsb one, invalid all ones
// - refuse first mismatching identifier byte
// - last-byte mismatch refused on that byte
// - full match adopts address, sets flags
// - assign handled even when already resolved
// - bad check byte refused, assign discarded
// - directed read answered only when valid
// - directed reset when valid clears resolved, maybe valid
// - identifier block count is 11 hex
// - id bits 127:126 zero mean fixed
// - collision at own address regenerates random
module ars_slave import ars_pkg::*; #(
  parameter bit PSA_EN = 1'b0,                  // persistent address kept
  parameter bit RANDOM_EN = 1'b1,               // random id portion
  parameter bit FIXED_EN = 1'b0,                // fixed discoverable address
  parameter logic [6:0] FIXED_ADDR = 7'h10,     // plain default
  parameter logic [127:0] UNIQUE_DEVICE_IDENTIFIER_BASE = 128'h4000_0000_0000_0000_0000_0000_0000_0000,  // arbitrary
  parameter int RAND_W = ARS_RAND_W             // at least 22 for the lfsr taps
) (
  // device clock domain
  input wire logic clk,
  input wire logic resetn,
  input wire logic noise_in,                    // entropy pin, asynchronous
  // nonvolatile store, static pins
  input wire logic nv_valid,
  input wire logic [6:0] nv_addr,
  output logic nv_write,                        // one clk pulse
  output logic [6:0] nv_wdata,
  // resolution state for the device
  output ars_stat_t stat,
  // link domain, byte engine side
  input wire logic link_clk,
  input wire ars_evt_t evt,
  output ars_rsp_t rsp
);

  // ----------------------------------------------------------------
  // link domain storage
  // ----------------------------------------------------------------
  logic lk_rst_s1;                 // reset release synchroniser
  logic lk_rst_n;
  logic [1:0] init;                // start-up step
  logic nv_valid_s1;
  logic nv_valid_s2;
  logic [6:0] nv_addr_s1;
  logic [6:0] nv_addr_s2;
  ars_state_t state;
  logic [4:0] idx;                 // byte position in block
  logic get_gen;                   // pending read is the general one
  logic [6:0] asg_addr;            // address byte of an assignment
  ars_stat_t lk_stat;              // flags live here
  logic lk_nv_wr;                  // last update must be stored
  logic stat_tgl;                  // update event toward clk
  logic rand_req;                  // regenerate request toggle
  logic [RAND_W-1:0] rand_id;      // random portion in use
  logic rand_ack_s1;
  logic rand_ack_s2;
  logic rand_ack_s3;
  ars_rsp_t next_rsp;
  ars_state_t next_state;
  logic [1:0] next_init;
  logic [4:0] next_idx;
  logic next_get_gen;
  logic [6:0] next_asg_addr;
  ars_stat_t next_lk_stat;
  logic next_lk_nv_wr;
  logic next_stat_tgl;
  logic next_rand_req;
  logic [RAND_W-1:0] next_rand_id;

  // ----------------------------------------------------------------
  // clk domain storage
  // ----------------------------------------------------------------
  logic [RAND_W-1:0] lfsr;
  logic [RAND_W-1:0] rand_word;    // held for the link to copy
  logic rand_ack;
  logic rand_req_s1;
  logic rand_req_s2;
  logic rand_req_s3;
  logic stat_s1;
  logic stat_s2;
  logic stat_s3;
  logic noise_s1;
  logic noise_s2;
  logic [RAND_W-1:0] next_lfsr;
  logic [RAND_W-1:0] next_rand_word;
  logic next_rand_ack;
  ars_stat_t next_stat;
  logic next_nv_write;
  logic [6:0] next_nv_wdata;

  // identifier as seen on the bus
  logic [127:0] unique_device_identifier;
  logic [7:0] addr_byte;

  // byte of the identifier at block position i, msb first from 1
  function automatic logic [7:0] unique_device_identifier_byte(input logic [127:0] u, input logic [4:0] i);
    logic [127:0] sh;
    sh = u << {i - 5'h01, 3'h0};
    return sh[127:120];
  endfunction : unique_device_identifier_byte

  // ----------------------------------------------------------------
  // identifier and returned address byte
  // ----------------------------------------------------------------
  always_comb begin
    unique_device_identifier = UNIQUE_DEVICE_IDENTIFIER_BASE;
    if (RANDOM_EN) begin
      unique_device_identifier[RAND_W-1:0] = rand_id;
    end
    if (FIXED_EN) begin
      unique_device_identifier[127:126] = ARS_TYPE_FIXED;
    end
    addr_byte = {lk_stat.valid ? lk_stat.addr : ARS_NO_ADDR, 1'b1};
  end

  // ----------------------------------------------------------------
  // link reset: asserts at once, releases on link_clk
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lk_rst_s1 <= 1'b0;
      lk_rst_n <= 1'b0;
    end else begin
      lk_rst_s1 <= 1'b1;
      lk_rst_n <= lk_rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // link command logic, next values
  // ----------------------------------------------------------------
  always_comb begin
    logic upd;                     // flags changed this cycle
    logic regen;                   // random portion to renew
    logic hit;                     // directed code names us
    upd = 1'b0;
    regen = 1'b0;
    hit = 1'b0;
    next_rsp = '0;
    next_state = state;
    next_init = init;
    next_idx = idx;
    next_get_gen = get_gen;
    next_asg_addr = asg_addr;
    next_lk_stat = lk_stat;
    next_lk_nv_wr = lk_nv_wr;
    next_stat_tgl = stat_tgl;
    next_rand_req = rand_req;
    next_rand_id = rand_id;
    // fresh random word arrived from clk side
    if (rand_ack_s2 != rand_ack_s3) begin
      next_rand_id = rand_word;
    end
    if (init != ARS_INIT_DONE) begin
      // straps need two edges to settle before loading
      next_init = init + 2'h1;
      if (init == ARS_INIT_LOAD) begin
        next_lk_stat.resolved = 1'b0;
        next_lk_stat.notify = 1'b1;
        next_lk_stat.valid = 1'b0;
        if (PSA_EN) begin
          next_lk_stat.valid = nv_valid_s2;
          next_lk_stat.addr = nv_addr_s2;
        end else if (FIXED_EN) begin
          next_lk_stat.valid = 1'b1;
          next_lk_stat.addr = FIXED_ADDR;
        end
        regen = 1'b1;
        upd = 1'b1;
      end
    end else if (evt.stop) begin
      next_state = ARS_IDLE;
    end else if (evt.addr_valid) begin
      next_rsp.ack_valid = 1'b1;
      if (evt.data[7:1] != ARS_DEFAULT_ADDR) begin
        next_state = ARS_IDLE;
      end else if (!evt.data[0]) begin
        next_rsp.ack = 1'b1;
        next_state = ARS_CMD;
      end else if (state == ARS_WAIT_RD) begin
        next_rsp.ack = get_gen ? !lk_stat.resolved : 1'b1;
        next_state = next_rsp.ack ? ARS_READ : ARS_DROP;
        next_idx = ARS_IDX_COUNT;
      end else begin
        next_state = ARS_DROP;
      end
    end else if (evt.rx_valid) begin
      next_rsp.ack_valid = 1'b1;
      unique case (state)
        ARS_CMD: begin
          if (evt.data == ARS_CMD_PREPARE) begin
            next_rsp.ack = 1'b1;
            next_state = ARS_PEC_PREP;
          end else if (evt.data == ARS_CMD_RESET_GEN) begin
            next_rsp.ack = 1'b1;
            next_state = ARS_PEC_RST;
          end else if (evt.data == ARS_CMD_GET_GEN) begin
            next_rsp.ack = 1'b1;
            next_get_gen = 1'b1;
            next_state = ARS_WAIT_RD;
          end else if (evt.data == ARS_CMD_ASSIGN) begin
            next_rsp.ack = 1'b1;
            next_idx = ARS_IDX_COUNT;
            next_state = ARS_ASSIGN;
          end else if (evt.data <= ARS_CMD_GEN_LAST || evt.data == ARS_CMD_RSV_FE ||
                       evt.data == ARS_CMD_RSV_FF) begin
            next_state = ARS_DROP;
          end else begin
            hit = (evt.data[7:1] == lk_stat.addr) && lk_stat.valid;
            next_rsp.ack = hit;
            next_get_gen = 1'b0;
            if (evt.data[0]) begin
              next_state = hit ? ARS_WAIT_RD : ARS_DROP;
            end else begin
              next_state = hit ? ARS_PEC_RST : ARS_DROP;
            end
          end
        end
        ARS_PEC_PREP: begin
          next_state = ARS_DROP;
          if (evt.pec_ok) begin
            next_rsp.ack = 1'b1;
            next_lk_stat.resolved = 1'b0;
            next_lk_stat.notify = 1'b0;
            upd = 1'b1;
          end
        end
        ARS_PEC_RST: begin
          next_state = ARS_DROP;
          if (evt.pec_ok) begin
            next_rsp.ack = 1'b1;
            next_lk_stat.resolved = 1'b0;
            if (!PSA_EN && !FIXED_EN) begin
              next_lk_stat.valid = 1'b0;
            end
            regen = 1'b1;
            upd = 1'b1;
          end
        end
        ARS_ASSIGN: begin
          next_idx = idx + 5'h01;
          if (idx == ARS_IDX_COUNT) begin
            next_rsp.ack = (evt.data == ARS_BLOCK_COUNT);
          end else if (idx < ARS_IDX_ADDR) begin
            next_rsp.ack = (evt.data == unique_device_identifier_byte(unique_device_identifier, idx));
          end else if (idx == ARS_IDX_ADDR) begin
            next_rsp.ack = 1'b1;
            next_asg_addr = evt.data[7:1];
          end else begin
            // check byte gates the whole assignment
            next_rsp.ack = evt.pec_ok;
            if (evt.pec_ok) begin
              next_lk_stat.resolved = 1'b1;
              next_lk_stat.valid = 1'b1;
              if (!FIXED_EN) begin
                next_lk_stat.addr = asg_addr;
              end
              next_lk_nv_wr = PSA_EN;
              upd = 1'b1;
            end
          end
          if (!next_rsp.ack || idx == ARS_IDX_PEC) begin
            next_state = ARS_DROP;
          end
        end
        default: begin
          // idle, read or dropped packets: refuse further bytes
          next_state = ARS_DROP;
        end
      endcase
    end else if (evt.tx_req) begin
      next_rsp.tx_valid = 1'b1;
      next_rsp.tx_data = 8'hFF;
      if (state == ARS_READ) begin
        next_idx = idx + 5'h01;
        // block count, then id, then address
        if (idx == ARS_IDX_COUNT) begin
          next_rsp.tx_data = ARS_BLOCK_COUNT;
        end else if (idx < ARS_IDX_ADDR) begin
          next_rsp.tx_data = unique_device_identifier_byte(unique_device_identifier, idx);
        end else begin
          next_rsp.tx_data = addr_byte;
          next_rsp.tx_last = 1'b1;
          next_state = ARS_DROP;
        end
      end
    end
    // collision renews random, asks for resolution
    if (init == ARS_INIT_DONE && evt.collision) begin
      regen = 1'b1;
      next_lk_stat.notify = 1'b1;
      upd = 1'b1;
    end
    if (regen && RANDOM_EN) begin
      next_rand_req = ~rand_req;
    end
    if (upd) begin
      next_stat_tgl = ~stat_tgl;
      if (!(state == ARS_ASSIGN && idx == ARS_IDX_PEC)) begin
        next_lk_nv_wr = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // link command logic, registers
  // ----------------------------------------------------------------
  // flags written only by this process
  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      init <= 2'h0;
      nv_valid_s1 <= 1'b0;
      nv_valid_s2 <= 1'b0;
      nv_addr_s1 <= 7'h00;
      nv_addr_s2 <= 7'h00;
      rand_ack_s1 <= 1'b0;
      rand_ack_s2 <= 1'b0;
      rand_ack_s3 <= 1'b0;
      rsp <= '0;
      state <= ARS_IDLE;
      idx <= ARS_IDX_RST;
      get_gen <= 1'b0;
      asg_addr <= 7'h00;
      lk_stat <= '0;
      lk_nv_wr <= 1'b0;
      stat_tgl <= 1'b0;
      rand_req <= 1'b0;
      rand_id <= '0;
    end else begin
      nv_valid_s1 <= nv_valid;
      nv_valid_s2 <= nv_valid_s1;
      nv_addr_s1 <= nv_addr;
      nv_addr_s2 <= nv_addr_s1;
      rand_ack_s1 <= rand_ack;
      rand_ack_s2 <= rand_ack_s1;
      rand_ack_s3 <= rand_ack_s2;
      init <= next_init;
      rsp <= next_rsp;
      state <= next_state;
      idx <= next_idx;
      get_gen <= next_get_gen;
      asg_addr <= next_asg_addr;
      lk_stat <= next_lk_stat;
      lk_nv_wr <= next_lk_nv_wr;
      stat_tgl <= next_stat_tgl;
      rand_req <= next_rand_req;
      rand_id <= next_rand_id;
    end
  end

  // ----------------------------------------------------------------
  // clk side: random source and status capture, next values
  // ----------------------------------------------------------------
  // link words are copied only after a toggle edge; they stay put for a
  // whole link cycle, far longer than the three clk edges of the crossing
  always_comb begin
    next_lfsr = {lfsr[RAND_W-2:0], lfsr[RAND_W-1] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0] ^ noise_s2};
    next_rand_word = rand_word;
    next_rand_ack = rand_ack;
    next_stat = stat;
    next_nv_write = 1'b0;
    next_nv_wdata = nv_wdata;
    if (rand_req_s2 != rand_req_s3) begin
      next_rand_word = lfsr;
      next_rand_ack = ~rand_ack;
    end
    if (stat_s2 != stat_s3) begin
      next_stat = lk_stat;
      next_nv_write = lk_nv_wr;
      next_nv_wdata = lk_stat.addr;
    end
  end

  // ----------------------------------------------------------------
  // clk side registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr <= '1;
      rand_word <= '0;
      rand_ack <= 1'b0;
      rand_req_s1 <= 1'b0;
      rand_req_s2 <= 1'b0;
      rand_req_s3 <= 1'b0;
      stat_s1 <= 1'b0;
      stat_s2 <= 1'b0;
      stat_s3 <= 1'b0;
      noise_s1 <= 1'b0;
      noise_s2 <= 1'b0;
      stat <= '0;
      nv_write <= 1'b0;
      nv_wdata <= 7'h00;
    end else begin
      noise_s1 <= noise_in;
      noise_s2 <= noise_s1;
      rand_req_s1 <= rand_req;
      rand_req_s2 <= rand_req_s1;
      rand_req_s3 <= rand_req_s2;
      stat_s1 <= stat_tgl;
      stat_s2 <= stat_s1;
      stat_s3 <= stat_s2;
      lfsr <= next_lfsr;
      rand_word <= next_rand_word;
      rand_ack <= next_rand_ack;
      stat <= next_stat;
      nv_write <= next_nv_write;
      nv_wdata <= next_nv_wdata;
    end
  end

endmodule : ars_slave

/* File: tb.sv */
// tb: self-checking bench of the address resolution slave.
// assumes a fixed identifier (no random part) and no persistent address.
`timescale 1ns/1ns
module tb import ars_pkg::*;;
  // ------------------------------
  // clocks, design, partner
  // ------------------------------
  localparam logic [127:0] UNIQUE_DEVICE_IDENTIFIER = 128'h4A5B_6C7D_0123_4567_89AB_CDEF_1357_9BDF;  // arbitrary
  localparam logic [5:0] F_RX = 6'h10, F_PEC = 6'h18, F_TX = 6'h04, F_STOP = 6'h02;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn;              // starts unknown so the first drive low is a falling edge
  ars_evt_t evt;
  ars_rsp_t rsp;
  ars_stat_t stat;
  ars_rsp_t r;               // last answer seen
  logic nv_write;            // persistent store strobe
  logic nv_seen = 1'b0;      // a store strobe was seen
  int failures = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  // a device with no persistent address must never strobe its store
  always @(posedge clk) nv_seen <= nv_seen | nv_write;
  // 125 ns link period, phase unrelated to clk
  always begin
    #63 link_clk = 1'b1;
    #62 link_clk = 1'b0;
  end
  ars_slave #(.RANDOM_EN(1'b0), .UNIQUE_DEVICE_IDENTIFIER_BASE(UNIQUE_DEVICE_IDENTIFIER)) ars_slave_inst (.clk(clk), .resetn(resetn),
    .noise_in(1'b0), .nv_valid(1'b0), .nv_addr(7'h00), .nv_write(nv_write), .nv_wdata(),
    .stat(stat), .link_clk(link_clk), .evt(evt), .rsp(rsp));
  ars_host ars_host_inst (.link_clk(link_clk), .evt(evt), .rsp(rsp));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task check(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task stop_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // address then command byte
  task cmd(input logic [7:0] c, input logic ea);
    ars_host_inst.start(1'b0, r);
    check("addr_ack", r.ack, 1'b1);
    ars_host_inst.send(F_RX, c, r);
    check("cmd_ack", r.ack, ea);
  endtask : cmd
  // check byte then stop; after a refusal the check byte is refused too
  task fin(input logic ea);
    ars_host_inst.send(F_PEC, 8'h00, r);
    check("pec_ack", r.ack, ea);
    ars_host_inst.send(F_STOP, 8'h00, r);
  endtask : fin
  task rd_block(input logic ea, input logic [6:0] a);
    logic [7:0] e;
    ars_host_inst.start(1'b1, r);
    check("read_ack", r.ack, ea);
    for (int i = 0; i < 18 && ea; i++) begin
      e = i == 0 ? 8'h11 : i == 17 ? {a, 1'b1} : UNIQUE_DEVICE_IDENTIFIER[135 - 8 * i -: 8];
      ars_host_inst.send(F_TX, 8'h00, r);
      check("tx_byte", r.tx_data, e);
      check("tx_last", r.tx_last, i == 17);
    end
    ars_host_inst.send(F_STOP, 8'h00, r);
  endtask : rd_block
  // whole assignment; refusals expected from the first differing byte on
  // any refused byte marks the target absent
  task assign_id(input logic [127:0] u, input logic [7:0] a, input logic pk);
    logic m;
    m = 1'b1;
    cmd(8'h04, 1'b1);
    ars_host_inst.send(F_RX, 8'h11, r);
    check("count_ack", r.ack, 1'b1);
    for (int i = 15; i >= 0; i--) begin
      m = m && u[8 * i +: 8] == UNIQUE_DEVICE_IDENTIFIER[8 * i +: 8];
      ars_host_inst.send(F_RX, u[8 * i +: 8], r);
      check("id_ack", r.ack, m);
    end
    ars_host_inst.send(F_RX, a, r);
    check("new_addr_ack", r.ack, m);
    ars_host_inst.send(pk ? F_PEC : F_RX, 8'h00, r);
    check("pec_ack", r.ack, m && pk);
    ars_host_inst.send(F_STOP, 8'h00, r);
  endtask : assign_id
  // stat lags the link side by a few clk
  task flags(input logic res, input logic val);
    repeat (8) @(posedge clk);
    check("resolved", stat.resolved, res);
    check("valid", stat.valid, val);
    check("nv_write", nv_seen, 1'b0);
  endtask : flags
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_power;
    check("resolved", stat.resolved, 1'b0);
    check("valid", stat.valid, 1'b0);
    check("notify", stat.notify, 1'b1);
  endtask : t_power
  task t_refuse;
    logic [7:0] rc [5];
    rc = '{8'h00, 8'h05, 8'h1F, 8'hFE, 8'hFF};
    ars_host_inst.send(6'h20, 8'h44, r);
    check("foreign", {r.ack_valid, r.ack}, 8'h02);
    fin(1'b0);
    for (int i = 0; i < 5; i++) begin
      cmd(rc[i], 1'b0);
      fin(1'b0);
    end
  endtask : t_refuse
  task t_prepare_read;
    cmd(8'h01, 1'b1);
    fin(1'b1);
    flags(1'b0, 1'b0);
    check("notify", stat.notify, 1'b0);
    cmd(8'h03, 1'b1);
    rd_block(1'b1, 7'h7F);
  endtask : t_prepare_read
  task t_assign;
    assign_id(UNIQUE_DEVICE_IDENTIFIER ^ (128'h1 << 80), 8'h5B, 1'b1);
    flags(1'b0, 1'b0);
    assign_id(UNIQUE_DEVICE_IDENTIFIER ^ 128'h1, 8'h5B, 1'b1);
    flags(1'b0, 1'b0);
    assign_id(UNIQUE_DEVICE_IDENTIFIER, 8'h5B, 1'b0);
    flags(1'b0, 1'b0);
    assign_id(UNIQUE_DEVICE_IDENTIFIER, 8'h5B, 1'b1);
    flags(1'b1, 1'b1);
    check("addr", stat.addr, 8'h2D);
    cmd(8'h03, 1'b1);
    rd_block(1'b0, 7'h00);
    assign_id(UNIQUE_DEVICE_IDENTIFIER, 8'h34, 1'b1);
    flags(1'b1, 1'b1);
    check("addr", stat.addr, 8'h1A);
  endtask : t_assign
  task t_directed;
    cmd(8'h5B, 1'b0);
    fin(1'b0);
    cmd(8'h35, 1'b1);
    rd_block(1'b1, 7'h1A);
    cmd(8'h01, 1'b1);
    fin(1'b1);
    flags(1'b0, 1'b1);
    cmd(8'h34, 1'b1);
    fin(1'b1);
    flags(1'b0, 1'b0);
    cmd(8'h35, 1'b0);
    fin(1'b0);
  endtask : t_directed
  task t_resets;
    assign_id(UNIQUE_DEVICE_IDENTIFIER, 8'h5B, 1'b1);
    flags(1'b1, 1'b1);
    cmd(8'h02, 1'b1);
    fin(1'b1);
    flags(1'b0, 1'b0);
    ars_host_inst.send(6'h01, 8'h00, r);
    repeat (8) @(posedge clk);
    // raised notify asks the master to resolve
    check("notify", stat.notify, 1'b1);
  endtask : t_resets
  // ------------------------------
  // main sequence and hang guard
  // ------------------------------
  initial begin
    // falling edge here so both domains see the asynchronous reset
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge link_clk);
    t_power();
    t_refuse();
    t_prepare_read();
    t_assign();
    t_directed();
    t_resets();
    stop_test();
  end
  initial begin
    #400000;
    failures++;
    stop_test();
  end
endmodule : tb
